/* File: verilog/acp_clock_power.sv */
// Clock source, dividers and power flags of the converter
//
// Overview of operation
// - Modulator clock is converter clock halved
// - Diagnostic counter at converter clock over 32
// - Mux picks pin clock or oscillator
// - Converter divider 1,2,3,4,8 by three bits
// - All channels share one divided phase
// - Bit clock divider 1,2,4,8 by two bits
// - Serial mode: oscillator default, bit selects pin
// - Pin mode always uses pin clock
// - Ignore start and reset 150 us after switch
// - Digital supply loss or reset pin low resets device; analog loss does not
// - Leave reset, start converting if start high
// - Power-on sets flags; write one clears
// - Analog monitors latch low-supply and header flags
// - Write one clears analog low-supply flag
// - Low digital supply also sets analog flag
// - Pin mode disables header power flag
// - High reference range forces single input range
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.svh"
module acp_clock_power #(
    parameter int GUARD_CYC  = `ACP_GUARD_CYC,  // Control-pin guard after switch
    parameter int CHANNELS   = 8,               // Converter channels
    parameter int DIAG_W     = 16               // Diagnostic counter width
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    // Avalon-MM slave
    input  wire acp_pkg::acp_av_req_t  i_av,
    output logic [31:0]                o_av_readdata,
    output logic                       o_av_waitrequest,
    // Clock sources, sampled as edge pulses
    input  wire logic                  i_ext_clock_pin,
    input  wire logic                  i_osc_clk,
    // Mode, control pins and monitors
    input  wire logic                  i_pin_mode,
    input  wire logic                  i_start_pin,
    input  wire logic                  i_reset_pin_n,
    input  wire acp_pkg::acp_pwr_t     i_pwr,
    input  wire logic [CHANNELS-1:0]   i_ch_double_range,
    // Derived clock enables and status
    output logic                       o_conv_clk_en,
    output logic                       o_mod_clk_en,
    output logic                       o_frame_port_bit_clock_en,
    output logic                       o_run,
    output logic                       o_start,
    output logic                       o_device_reset,
    output logic                       o_header_power_flag,
    output logic [CHANNELS-1:0]        o_ch_double_range
);
    import acp_pkg::*;

    // ==============================
    // Input synchronisation
    localparam int NS = 10;
    logic [NS-1:0] pins_s;               // Synchronised pins
    acp_sync2 #(.W(NS)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_ext_clock_pin, i_osc_clk, i_pin_mode, i_start_pin,
                     i_reset_pin_n, i_pwr}),
        .o_sync    (pins_s)
    );
    wire       ext_s   = pins_s[9];
    wire       osc_s   = pins_s[8];
    wire       pin_md  = pins_s[7];
    wire       start_s = pins_s[6];
    wire       rstp_n  = pins_s[5];
    acp_pwr_t  pwr_s;                    // Monitors after two stages
    assign pwr_s = acp_pwr_t'(pins_s[4:0]);

    // Digital supply good; reads low until the stages fill after reset
    wire dig_ok = pwr_s.dig_supply_ok;

    // ==============================
    // Registers
    logic       clk_sel;                 // Source select, 1 = pin clock
    logic [2:0] div_sel;                 // Converter divide select
    logic [1:0] port_bit_clock_divide_sel;
    logic       ref_range_sel;           // High reference range
    logic       por_flag;                // Power-on flag
    logic       analog_low_supply_flag;  // Sticky analog low flag
    logic       hdr_flag;                // Header power flag
    logic [DIAG_W-1:0] clock_diag_counter;

    wire wr = i_av.write & ~o_av_waitrequest;
    wire wr_clk  = wr && (i_av.address == `ACP_ADDR_CLK_CFG);
    wire wr_gen  = wr && (i_av.address == `ACP_ADDR_GEN_CFG);
    wire wr_stat = wr && (i_av.address == `ACP_ADDR_STATUS);
    wire clr_por = wr_stat & i_av.writedata[`ACP_POR_FLAG_BIT];
    wire clr_alv = wr_stat & i_av.writedata[`ACP_ANALOG_LOW_SUPPLY_FLAG_BIT];

    // ==============================
    // Source mux and edge pulses
    wire src_ext = pin_md | clk_sel;
    logic ext_d, osc_d;                  // Edge history
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ext_d <= 1'b0;
            osc_d <= 1'b0;
        end else begin
            ext_d <= ext_s;
            osc_d <= osc_s;
        end
    end
    wire ext_tick = ext_s & ~ext_d;
    wire osc_tick = osc_s & ~osc_d;
    wire sel_tick = src_ext ? ext_tick : osc_tick;

    // Converter divide ratio decode function
    function automatic logic [3:0] conv_ratio(input logic [2:0] s);
        if (s == `ACP_DIV_SEL_2)      conv_ratio = 4'h2;
        else if (s == `ACP_DIV_SEL_3) conv_ratio = 4'h3;
        else if (s == `ACP_DIV_SEL_4) conv_ratio = 4'h4;
        else if (s == `ACP_DIV_SEL_8) conv_ratio = 4'h8;
        else                          conv_ratio = 4'h1;
    endfunction
    wire [3:0] bck_ratio = 4'h1 << port_bit_clock_divide_sel;

    // ==============================
    // Dividers; one converter divider feeds every channel
    logic src_sw;                        // Source changed one cycle earlier
    logic conv_tick, mod_tick, diag_tick, bck_tick;
    acp_clk_div #(.W(4)) u_conv (
        .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_tick (sel_tick),
        .i_ratio (conv_ratio(div_sel)), .i_sync (src_sw), .o_tick (conv_tick)
    );
    acp_clk_div #(.W(4)) u_mod (
        .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_tick (conv_tick),
        .i_ratio (`ACP_MOD_DIV), .i_sync (src_sw), .o_tick (mod_tick)
    );
    acp_clk_div #(.W(6)) u_diag (
        .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_tick (conv_tick),
        .i_ratio (`ACP_DIAG_DIV), .i_sync (1'b0), .o_tick (diag_tick)
    );
    acp_clk_div #(.W(4)) u_bck (
        .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_tick (sel_tick),
        .i_ratio (bck_ratio), .i_sync (src_sw), .o_tick (bck_tick)
    );

    // ==============================
    // Control-pin guard after a source change
    logic src_q;                         // Previous source
    localparam int GW = $clog2(GUARD_CYC+1);
    logic [GW-1:0] guard;                // Guard cycles left
    wire guard_on = (guard != '0);
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            src_q <= 1'b0;
            src_sw <= 1'b0;
            guard <= '0;
        end else begin
            src_q  <= src_ext;
            src_sw <= src_ext ^ src_q;
            if (src_ext ^ src_q) begin
                guard <= GW'(GUARD_CYC);
            end else if (guard_on) begin
                guard <= guard - 1'b1;
            end
        end
    end

    // ==============================
    // Register writes; bus reset is the digital supply reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            clk_sel <= 1'b0;
            div_sel <= `ACP_DIV_SEL_1;
            port_bit_clock_divide_sel <= 2'h0;
            ref_range_sel <= 1'b0;
        end else begin
            if (wr_clk) begin
                clk_sel <= i_av.writedata[`ACP_CLK_SEL_BIT];
                div_sel <= i_av.writedata[`ACP_CLK_DIV_MSB:`ACP_CLK_DIV_LSB];
                port_bit_clock_divide_sel <= i_av.writedata[`ACP_BCK_DIV_MSB:`ACP_BCK_DIV_LSB];
            end
            if (wr_gen) begin
                ref_range_sel <= i_av.writedata[`ACP_REF_RANGE_SEL_BIT];
            end
        end
    end

    // ==============================
    // Sticky power flags; set beats clear
    wire analog_low = ~&pwr_s.analog_ok;
    wire dig_low    = ~dig_ok;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            por_flag <= 1'b1;
            analog_low_supply_flag <= 1'b1;
            hdr_flag <= 1'b1;
        end else begin
            por_flag <= dig_low | (por_flag & ~clr_por);
            analog_low_supply_flag <= analog_low | dig_low |
                (analog_low_supply_flag & ~clr_alv);
            hdr_flag <= analog_low | dig_low |
                (hdr_flag & ~(clr_por | clr_alv));
        end
    end

    // ==============================
    // Diagnostic counter, free-running, wraps
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            clock_diag_counter <= '0;
        end else if (diag_tick) begin
            clock_diag_counter <= clock_diag_counter + 1'b1;
        end
    end

    // ==============================
    // Read mux and one-wait-state handshake
    wire [31:0] rd_mux =
        (i_av.address == `ACP_ADDR_CLK_CFG) ?
            32'({port_bit_clock_divide_sel, div_sel, clk_sel}) :
        (i_av.address == `ACP_ADDR_GEN_CFG)  ? 32'(ref_range_sel) :
        (i_av.address == `ACP_ADDR_STATUS)   ?
            32'({analog_low_supply_flag, por_flag}) :
        (i_av.address == `ACP_ADDR_DIAG_CNT) ? 32'(clock_diag_counter) :
        (i_av.address == `ACP_ADDR_CTRL_STAT) ? 32'({guard_on, src_ext}) :
        `ACP_READ_ZERO;
    // Read data is taken while the request waits, so it stands at the
    // edge where waitrequest is seen low
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_av_waitrequest <= 1'b1;
            o_av_readdata <= `ACP_READ_ZERO;
        end else begin
            o_av_waitrequest <= ~((i_av.read | i_av.write) & o_av_waitrequest);
            if (i_av.read & o_av_waitrequest) begin
                o_av_readdata <= rd_mux;
            end
        end
    end

    // ==============================
    // Run control and outputs
    logic start_q;                       // Start pin held across guard
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || dig_low) begin
            start_q <= 1'b0;
            o_device_reset <= 1'b1;
            o_run <= 1'b0;
        end else if (!guard_on) begin
            start_q <= start_s;
            o_device_reset <= ~rstp_n;
            // Run and reset move on one edge, so they never overlap
            o_run <= rstp_n & start_s;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_conv_clk_en <= 1'b0;
            o_mod_clk_en <= 1'b0;
            o_frame_port_bit_clock_en <= 1'b0;
            o_start <= 1'b0;
            o_header_power_flag <= 1'b0;
            o_ch_double_range <= '0;
        end else begin
            o_conv_clk_en <= conv_tick;
            o_mod_clk_en <= mod_tick;
            o_frame_port_bit_clock_en <= bck_tick;
            o_start <= start_q;
            o_header_power_flag <= hdr_flag & ~pin_md;
            o_ch_double_range <= ref_range_sel ? '0 : i_ch_double_range;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/acp_regs.svh */
// Register map and constants of the clock and power-flag block
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

// ==============================
// Register byte addresses
`define ACP_ADDR_CLK_CFG    6'h00
`define ACP_ADDR_GEN_CFG    6'h04
`define ACP_ADDR_STATUS     6'h08
`define ACP_ADDR_DIAG_CNT   6'h0C
`define ACP_ADDR_CTRL_STAT  6'h10

// ==============================
// Field positions
`define ACP_CLK_SEL_BIT     0
`define ACP_CLK_DIV_LSB     1
`define ACP_CLK_DIV_MSB     3
`define ACP_BCK_DIV_LSB     4
`define ACP_BCK_DIV_MSB     5
`define ACP_REF_RANGE_SEL_BIT     0
`define ACP_POR_FLAG_BIT    0
`define ACP_ANALOG_LOW_SUPPLY_FLAG_BIT    1

// ==============================
// Reset values and encodings
`define ACP_CLK_CFG_RST     6'h00
`define ACP_DIV_SEL_1       3'h0
`define ACP_DIV_SEL_2       3'h1
`define ACP_DIV_SEL_3       3'h2
`define ACP_DIV_SEL_4       3'h3
`define ACP_DIV_SEL_8       3'h4
`define ACP_MOD_DIV         4'h2
`define ACP_DIAG_DIV        6'h20
`define ACP_READ_ZERO       32'h00000000

// ==============================
// Timing
`define ACP_CLK_MHZ         100
`define ACP_GUARD_US        150
`define ACP_GUARD_CYC       (`ACP_GUARD_US * `ACP_CLK_MHZ)

`endif

/* File: verilog/acp_pkg.sv */
// Types shared by the clock and power-flag block
package acp_pkg;
    // Avalon-MM request bundle
    typedef struct packed {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } acp_av_req_t;

    // Power monitor inputs, synchronised to the system clock inside the block
    typedef struct packed {
        logic        dig_supply_ok;
        logic [3:0]  analog_ok;
    } acp_pwr_t;
endpackage

/* File: verilog/acp_clk_div.sv */
// Programmable clock-enable divider with tick output
`timescale 1ns/10ps
`default_nettype none
module acp_clk_div #(
    parameter int W = 4
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_tick,    // Input rate pulse
    input  wire logic [W-1:0] i_ratio,   // Divide ratio, at least 1
    input  wire logic         i_sync,    // Restart the phase
    output logic              o_tick     // Output rate pulse
);
    logic [W-1:0] count;                 // Phase counter
    wire          wrap = (count >= i_ratio - W'(1));

    // ==============================
    // Phase counter; o_tick is combinational from a registered count
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || i_sync) begin
            count <= '0;
        end else if (i_tick) begin
            count <= wrap ? '0 : count + W'(1);
        end
    end
    assign o_tick = i_tick & wrap;
endmodule
`default_nettype wire

/* File: verilog/acp_sync2.sv */
// Two-flop synchroniser for a bus of levels
`timescale 1ns/10ps
`default_nettype none
module acp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,   // Pins from outside
    output logic      [W-1:0] o_sync     // Safe copies
);
    logic [W-1:0] meta;                  // First stage, read only below

    // ==============================
    // Two stages; reset to zero
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: tb/acp_host_model.sv */
// Host-side clock sources for the clock and power block
`timescale 1ns/10ps
`default_nettype none
module acp_host_model (
    input  wire logic i_sys_clk,
    output wire logic o_ext_clock_pin,
    output wire logic o_osc_clk
);
    // ==============================
    // Free-running sources
    logic [3:0] ext_cnt = 4'h0; // Pin clock phase, period 10
    logic [2:0] osc_cnt = 3'h0; // Oscillator phase, period 8
    // Pin clock never stops, so switching away from it stays safe
    always @(posedge i_sys_clk) begin
        ext_cnt <= (ext_cnt == 4'h9) ? 4'h0 : ext_cnt + 4'h1;
        osc_cnt <= osc_cnt + 3'h1;
    end
    assign o_ext_clock_pin = (ext_cnt < 4'h5);
    assign o_osc_clk       = osc_cnt[2];
endmodule
`default_nettype wire

/* File: tb/acp_clock_power_monitor.sv */
// Checker of the clock and power block ports
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.svh"
module acp_clock_power_monitor #(
    parameter int GUARD_CYC = 20,
    parameter int CHANNELS  = 8,
    parameter int DIAG_W    = 16
) (
    input wire logic                 i_sys_clk,
    input wire logic                 i_rst_n,
    input wire acp_pkg::acp_av_req_t i_av,
    input wire logic [31:0]          o_av_readdata,
    input wire logic                 o_av_waitrequest,
    input wire logic                 i_pin_mode,
    input wire acp_pkg::acp_pwr_t    i_pwr,
    input wire logic                 o_conv_clk_en,
    input wire logic                 o_mod_clk_en,
    input wire logic                 o_run,
    input wire logic                 o_device_reset,
    input wire logic                 o_header_power_flag,
    input wire logic [CHANNELS-1:0]  o_ch_double_range
);
    import acp_pkg::*;
    // ==============================
    // Helper state
    logic       ref_hi;    // Shadow of the range select
    logic [2:0] conv_seen; // Converter pulses since last modulator pulse
    logic       armed;     // A full modulator period seen since a write
    logic       pm_q;      // Pin mode one cycle ago
    logic [4:0] quiet;     // Recent writes or mode changes
    wire        wr_take = !o_av_waitrequest && i_av.write;
    wire        upset   = wr_take || (pm_q != i_pin_mode);
    // Writes and mode changes restart phases a few cycles later, so re-arm
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ref_hi    <= 1'h0;
            conv_seen <= 3'h0;
            armed     <= 1'h0;
            pm_q      <= 1'h0;
            quiet     <= 5'h00;
        end else begin
            if (wr_take && i_av.address == `ACP_ADDR_GEN_CFG) ref_hi <= i_av.writedata[0];
            conv_seen <= o_mod_clk_en ? {2'h0, o_conv_clk_en} : conv_seen + {2'h0, o_conv_clk_en};
            pm_q      <= i_pin_mode;
            quiet     <= {quiet[3:0], upset};
            armed     <= (upset || |quiet) ? 1'h0 : (armed | o_mod_clk_en);
        end
    end
    // ==============================
    // Properties
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_bad_rd;
        !o_av_waitrequest && i_av.read && (i_av.address > `ACP_ADDR_CTRL_STAT);
    endsequence
    sequence s_pin_held;
        i_pin_mode [*6];
    endsequence
    chk_wait_one_cycle: assert property (!o_av_waitrequest |=> o_av_waitrequest)
        else $error("waitrequest low two cycles");
    chk_wait_needs_req: assert property (!o_av_waitrequest |-> (i_av.read || i_av.write))
        else $error("waitrequest low without request");
    chk_unmapped_zero: assert property (s_bad_rd |-> (o_av_readdata == 32'h0))
        else $error("unmapped read not zero");
    chk_range_force: assert property ((ref_hi && $past(ref_hi)) |-> (o_ch_double_range == '0))
        else $error("double range not forced off");
    chk_mod_half: assert property ((o_mod_clk_en && armed) |-> (conv_seen == 3'h2))
        else $error("modulator not half converter rate");
    chk_pin_hides_flag: assert property (s_pin_held |-> !o_header_power_flag)
        else $error("header flag shown in pin mode");
    chk_analog_latch: assert property ((!(&i_pwr.analog_ok) && !i_pin_mode) |-> ##[1:6] o_header_power_flag)
        else $error("analog low not latched");
    chk_dig_low_run: assert property (!i_pwr.dig_supply_ok |-> ##[1:6] !o_run)
        else $error("digital supply low keeps running");
    chk_run_not_reset: assert property (o_run |-> !o_device_reset)
        else $error("running while in reset");
endmodule
bind acp_clock_power acp_clock_power_monitor #(.GUARD_CYC(GUARD_CYC), .CHANNELS(CHANNELS),
    .DIAG_W(DIAG_W)) u_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_av(i_av),
    .o_av_readdata(o_av_readdata), .o_av_waitrequest(o_av_waitrequest), .i_pin_mode(i_pin_mode),
    .i_pwr(i_pwr), .o_conv_clk_en(o_conv_clk_en), .o_mod_clk_en(o_mod_clk_en), .o_run(o_run),
    .o_device_reset(o_device_reset), .o_header_power_flag(o_header_power_flag),
    .o_ch_double_range(o_ch_double_range));
`default_nettype wire

/* File: tb/acp_clock_power_test.sv */
// Self-checking bench of the clock and power block
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.svh"
module acp_clock_power_test;
    import acp_pkg::*;
    // ==============================
    // Signals
    logic        clk = 1'h0;
    logic        rst_n, wreq, ext, osc, pin_mode, start, rpin_n;
    logic        conv, modc, bitc, run, strt, dev_rst, hflag;
    acp_av_req_t av;
    acp_pwr_t    pwr;
    logic [31:0] rdata, q;  // Read data and last captured word
    logic [7:0]  dbl, dbl_o;
    int          miscompares = 0, n_checks = 0, cyc = 0;
    int          rat [6] = '{1, 2, 3, 4, 8, 1}; // Converter ratios per select
    always #5 clk = ~clk;
    acp_host_model host (.i_sys_clk(clk), .o_ext_clock_pin(ext), .o_osc_clk(osc));
    // Short guard and narrow counter keep the run brief
    acp_clock_power #(.GUARD_CYC(20), .DIAG_W(4)) dut (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_av(av), .o_av_readdata(rdata), .o_av_waitrequest(wreq), .i_ext_clock_pin(ext),
        .i_osc_clk(osc), .i_pin_mode(pin_mode), .i_start_pin(start), .i_reset_pin_n(rpin_n),
        .i_pwr(pwr), .i_ch_double_range(dbl), .o_conv_clk_en(conv), .o_mod_clk_en(modc),
        .o_frame_port_bit_clock_en(bitc), .o_run(run), .o_start(strt),
        .o_device_reset(dev_rst), .o_header_power_flag(hflag), .o_ch_double_range(dbl_o));
    // ==============================
    // Common tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            give_verdict;
        end
    end
    // One Avalon cycle, held until waitrequest low; read data lands in q
    task automatic av_xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        av <= '{address: a, read: ~w, write: w, writedata: d};
        // Flops update after this point, so values read are those of the edge
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'h0 && n < 40);
        q = rdata;
        if (n >= 40) miscompares++;
        av <= '{address: a, read: 1'h0, write: 1'h0, writedata: d};
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? conv : (s == 1) ? modc : bitc;
    endfunction
    // Wait for one pulse, then count cycles to the next
    task automatic gap(input int s, input int exp);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (pick(s) !== 1'h1 && n < 300);
        end
        chk(n, exp);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // ==============================
    // Scenarios
    task automatic t_reset;
        av_xfer(1'h0, `ACP_ADDR_STATUS, 32'h0);   chk(q, 32'h3);
        av_xfer(1'h0, `ACP_ADDR_CLK_CFG, 32'h0);  chk(q, 32'h0);
        av_xfer(1'h0, `ACP_ADDR_CTRL_STAT, 32'h0); chk(q[0], 1'h0);
        chk(hflag, 1'h1);
        chk(run, 1'h1);
        chk(strt, 1'h1);
    endtask
    task automatic t_div;
        for (int i = 0; i < 6; i++) begin
            av_xfer(1'h1, `ACP_ADDR_CLK_CFG, {26'h0, i[1:0], i[2:0], 1'h0});
            gap(0, 8 * rat[i]);
            gap(1, 16 * rat[i]);
            gap(2, 8 << i[1:0]);
        end
    endtask
    task automatic t_source;
        av_xfer(1'h1, `ACP_ADDR_CLK_CFG, 32'h1);
        av_xfer(1'h0, `ACP_ADDR_CTRL_STAT, 32'h0); chk(q[1:0], 2'h3);
        @(posedge clk) rpin_n <= 1'h0;
        wait_n(5); chk(dev_rst, 1'h0);
        @(posedge clk) rpin_n <= 1'h1;
        wait_n(30);
        av_xfer(1'h0, `ACP_ADDR_CTRL_STAT, 32'h0); chk(q[1:0], 2'h1);
        gap(0, 10);
        @(posedge clk) rpin_n <= 1'h0;
        wait_n(6); chk(dev_rst, 1'h1);
        @(posedge clk) rpin_n <= 1'h1;
        wait_n(12); chk(run, 1'h1);
        av_xfer(1'h1, `ACP_ADDR_CLK_CFG, 32'h0);
        wait_n(30); gap(0, 8);
    endtask
    task automatic t_pin;
        @(posedge clk) pin_mode <= 1'h1;
        gap(0, 10);
        chk(hflag, 1'h0);
        av_xfer(1'h0, `ACP_ADDR_CTRL_STAT, 32'h0); chk(q[0], 1'h1);
        @(posedge clk) pin_mode <= 1'h0;
    endtask
    task automatic t_power;
        av_xfer(1'h1, `ACP_ADDR_STATUS, 32'h3);
        av_xfer(1'h0, `ACP_ADDR_STATUS, 32'h0); chk(q, 32'h0);
        chk(hflag, 1'h0);
        @(posedge clk) pwr.analog_ok <= 4'hB;
        wait_n(8);
        @(posedge clk) pwr.analog_ok <= 4'hF;
        av_xfer(1'h0, `ACP_ADDR_STATUS, 32'h0); chk(q, 32'h2);
        chk(hflag, 1'h1);
        chk(dev_rst, 1'h0);
        av_xfer(1'h1, `ACP_ADDR_STATUS, 32'h2);
        av_xfer(1'h0, `ACP_ADDR_STATUS, 32'h0); chk(q, 32'h0);
        @(posedge clk) pwr.dig_supply_ok <= 1'h0;
        wait_n(8); chk(run, 1'h0);
        @(posedge clk) pwr.dig_supply_ok <= 1'h1;
        wait_n(12);
        av_xfer(1'h0, `ACP_ADDR_STATUS, 32'h0); chk(q[1], 1'h1);
    endtask
    task automatic t_misc;
        av_xfer(1'h1, `ACP_ADDR_GEN_CFG, 32'h1);
        wait_n(6); chk(dbl_o, 8'h00);
        av_xfer(1'h1, `ACP_ADDR_GEN_CFG, 32'h0);
        wait_n(6); chk(dbl_o, 8'hA5);
        av_xfer(1'h1, 6'h3C, 32'hFF);
        av_xfer(1'h0, 6'h3C, 32'h0); chk(q, 32'h0);
        @(posedge clk) start <= 1'h0;
        wait_n(6); chk(run, 1'h0);
        chk(strt, 1'h0);
    endtask
    // Reads 512 cycles apart see two counts each, across the wrap
    task automatic t_diag;
        logic [31:0] prev;
        prev = 32'h0;
        for (int k = 0; k < 9; k++) begin
            do @(negedge clk); while (cyc % 512 != 511);
            av_xfer(1'h0, `ACP_ADDR_DIAG_CNT, 32'h0);
            if (k > 0) chk((q - prev) & 32'hF, 32'h2);
            chk(q >> 4, 32'h0);
            prev = q;
        end
    endtask
    // ==============================
    // Main sequence
    initial begin
        rst_n = 1'h0;
        av = '0;
        pin_mode = 1'h0;
        start = 1'h1;
        rpin_n = 1'h1;
        pwr = '{1'h1, 4'hF};
        dbl = 8'hA5;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_reset;
        t_div;
        t_source;
        t_pin;
        t_power;
        t_misc;
        t_diag;
        give_verdict;
    end
endmodule
`default_nettype wire
